/* File: common/psp_pkg.sv */
package psp_pkg;
   // ------------------------------------------------------------
   // Register indices (byte address is index times four)
   // ------------------------------------------------------------
   localparam logic [7:0] idx_parallel_data_port = 8'h08;
   localparam logic [7:0] idx_control_pin_port = 8'h09;
   localparam logic [7:0] idx_interrupt_control = 8'h0b;
   localparam logic [7:0] idx_peripheral_int_flags = 8'h0c;
   localparam logic [7:0] idx_control_pin_direction_status = 8'h89;
   localparam logic [7:0] idx_data_pin_direction = 8'h88;
   localparam logic [7:0] idx_peripheral_int_enables = 8'h8c;
   localparam logic [7:0] idx_analog_pin_config = 8'h9f;
   localparam logic [7:0] idx_event_status = 8'ha0;
   localparam logic [7:0] idx_event_mask = 8'ha1;
   localparam int addr_w = 10;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int bit_ibf = 7;
   localparam int bit_obf = 6;
   localparam int bit_input_overflow_flag = 5;
   localparam int bit_mode = 4;
   localparam int bit_port_irq = 7;
   localparam int bit_gie = 7;
   localparam int bit_peie = 6;
   // Event status bits
   localparam int ev_wr_done = 0;
   localparam int ev_rd_done = 1;
   localparam int ev_overflow = 2;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] rst_dir_status = 8'h07;
   localparam logic [7:0] rst_zero = 8'h00;
   localparam logic [7:0] rst_data_dir = 8'hff;
   localparam logic [2:0] ev_mask_all = 3'h7;
   // Quarter-cycle phase count: Q1..Q4 as 0..3
   localparam logic [1:0] phase_q2 = 2'h1;
   localparam logic [1:0] phase_q4 = 2'h3;
   // Member order matches pin order: chip select is bit 2, read strobe bit 0
   typedef struct packed {
      logic cs_b;
      logic wr_b;
      logic rd_b;
   } strobe_type;
   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_wait_q2 = 3'b010,
      st_wait_q4 = 3'b100
   } done_state_type;
endpackage

/* File: core/parallel_slave_port.sv */
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
// Operation
// - The data port is a slave port only while mode select bit 4 is set, else plain I/O.
// - In slave mode control pins 0, 1 and 2 are read strobe, write strobe and chip select, low.
// - The external master reads and writes the latch asynchronously to the device clock.
// - Two latches share one address: firmware writes outbound, reads inbound.
// - In slave mode the data direction register is ignored; strobes steer the pins.
// - A write starts when chip select and write strobe are both first seen low.
// - When either goes high, input-full and the port irq flag set on Q4 after the next Q2.
// - Input-full clears when firmware reads the inbound latch or when slave mode is turned off.
// - A second write before the last byte is read sets the sticky overflow flag bit 5.
// - A read starts on both low, clears output-full at once and drives the outbound latch.
// - When either goes high after a read, the port irq flag sets on Q4 after the next Q2.
// - Output-full stays low until firmware writes a new outbound byte.
// - With slave mode off both full flags are held clear; overflow is kept.
// - The port irq flag latches each completed transfer; its enable gates the request.
// - Read strobe low with chip select low drives the outbound latch onto the pins.
// - Write strobe low with chip select low latches the data pins into the inbound latch.
module parallel_slave_port (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic clk_en_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [psp_pkg::addr_w-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [7:0] data_pin_i,
   output logic [7:0] data_pin_o,
   output logic [7:0] data_pin_oe_o,
   input wire logic [2:0] ctrl_pin_i,
   output logic [2:0] ctrl_pin_o,
   output logic [2:0] ctrl_pin_oe_o,
   output logic irq_o,
   output logic cpu_irq_o
);
   import psp_pkg::*;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0] out_latch;
   logic [7:0] in_latch;
   logic [7:0] data_dir;
   logic [2:0] ctrl_out;
   logic [2:0] ctrl_dir;
   logic slave_mode_select;
   logic input_full_flag;
   logic output_full_flag;
   logic input_overflow_flag;
   logic [7:0] interrupt_control;
   logic [7:0] peripheral_int_flags;
   logic [7:0] peripheral_int_enables;
   logic [2:0] analog_pin_select;
   logic [2:0] event_status;
   logic [2:0] event_mask;
   logic [1:0] phase;
   done_state_type done_state;
   logic done_is_write;
   strobe_type sync1;
   strobe_type sync2;
   logic wr_active;
   logic rd_active;
   logic wr_active_q;
   logic rd_active_q;
   logic [7:0] pin_sync1;
   logic [7:0] pin_sync2;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   logic acc;
   logic wr_acc;
   logic rd_acc;
   logic [7:0] wbyte;
   logic [7:0] reg_idx;
   logic addr_ok;
   logic data_rd;
   logic data_wr;
   logic wr_start;
   logic rd_start;
   logic wr_end;
   logic rd_end;
   logic completed;
   logic [7:0] next_rdata;

   assign acc = psel_i && penable_i && clk_en_i;
   assign wr_acc = acc && pwrite_i && addr_ok;
   assign rd_acc = acc && !pwrite_i && addr_ok;
   assign wbyte = pwdata_i[7:0];
   assign reg_idx = paddr_i[addr_w-1:2];
   assign data_rd = rd_acc && reg_idx == idx_parallel_data_port;
   assign data_wr = wr_acc && reg_idx == idx_parallel_data_port;

   always_comb begin
      addr_ok = 1'b1;
      next_rdata = rst_zero;
      case (reg_idx)
         idx_parallel_data_port:
            next_rdata = slave_mode_select ? in_latch : pin_sync2;
         idx_control_pin_port: next_rdata = {5'h00, sync2.cs_b, sync2.wr_b, sync2.rd_b};
         idx_interrupt_control: next_rdata = interrupt_control;
         idx_peripheral_int_flags: next_rdata = peripheral_int_flags;
         idx_control_pin_direction_status:
            next_rdata = {input_full_flag, output_full_flag, input_overflow_flag,
                          slave_mode_select, 1'b0, ctrl_dir};
         idx_data_pin_direction: next_rdata = data_dir;
         idx_peripheral_int_enables: next_rdata = peripheral_int_enables;
         idx_analog_pin_config: next_rdata = {5'h00, analog_pin_select};
         idx_event_status: next_rdata = {5'h00, event_status};
         idx_event_mask: next_rdata = {5'h00, event_mask};
         default: addr_ok = 1'b0;
      endcase
   end

   // Zero wait states; unmapped addresses answer with an error
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prdata_o <= 32'h0000_0000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else if (clk_en_i) begin
         pready_o <= psel_i && !penable_i;
         pslverr_o <= psel_i && !penable_i && !addr_ok;
         if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= {24'h00_0000, next_rdata};
         end
      end
   end

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // First stage read only by second stage
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1 <= '1;
         sync2 <= '1;
         pin_sync1 <= rst_zero;
         pin_sync2 <= rst_zero;
      end else if (clk_en_i) begin
         sync1 <= ctrl_pin_i;
         sync2 <= sync1;
         pin_sync1 <= data_pin_i;
         pin_sync2 <= pin_sync1;
      end
   end

   assign wr_active = slave_mode_select && !sync2.cs_b && !sync2.wr_b;
   assign rd_active = slave_mode_select && !sync2.cs_b && !sync2.rd_b;
   assign wr_start = wr_active && !wr_active_q;
   assign rd_start = rd_active && !rd_active_q;
   assign wr_end = !wr_active && wr_active_q;
   assign rd_end = !rd_active && rd_active_q;

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_active_q <= 1'b0;
         rd_active_q <= 1'b0;
      end else if (clk_en_i) begin
         wr_active_q <= wr_active;
         rd_active_q <= rd_active;
      end
   end

   // ------------------------------------------------------------
   // Inbound latch
   // ------------------------------------------------------------
   // Synchronised pins sampled while both strobes low; master holds data stable
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         in_latch <= rst_zero;
      end else if (clk_en_i && wr_active) begin
         in_latch <= pin_sync2;
      end
   end

   // ------------------------------------------------------------
   // Phase clock and completion
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         phase <= 2'h0;
      end else if (clk_en_i) begin
         phase <= phase + 2'h1;
      end
   end

   // A new end before completion is ignored; overlap is not expected
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         done_state <= st_idle;
         done_is_write <= 1'b0;
      end else if (clk_en_i) begin
         case (done_state)
            st_idle: begin
               if (wr_end || rd_end) begin
                  done_state <= st_wait_q2;
                  done_is_write <= wr_end;
               end
            end
            st_wait_q2: if (phase == phase_q2) done_state <= st_wait_q4;
            st_wait_q4: if (phase == phase_q4) done_state <= st_idle;
            default: done_state <= st_idle;
         endcase
      end
   end

   assign completed = done_state == st_wait_q4 && phase == phase_q4;

   // ------------------------------------------------------------
   // Status flags
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         input_full_flag <= 1'b0;
         output_full_flag <= 1'b0;
         input_overflow_flag <= 1'b0;
      end else if (clk_en_i) begin
         if (!slave_mode_select) begin
            input_full_flag <= 1'b0;
            output_full_flag <= 1'b0;
         end else begin
            if (completed && done_is_write) begin
               input_full_flag <= 1'b1;
            end else if (data_rd) begin
               input_full_flag <= 1'b0;
            end
            if (rd_start) begin
               output_full_flag <= 1'b0;
            end else if (data_wr) begin
               output_full_flag <= 1'b1;
            end
         end
         if (wr_start && input_full_flag) begin
            input_overflow_flag <= 1'b1;
         end else if (wr_acc && reg_idx == idx_control_pin_direction_status
                      && !wbyte[bit_input_overflow_flag]) begin
            input_overflow_flag <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Firmware registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_latch <= rst_zero;
         data_dir <= rst_data_dir;
         ctrl_out <= 3'h0;
         ctrl_dir <= rst_dir_status[2:0];
         slave_mode_select <= 1'b0;
         interrupt_control <= rst_zero;
         peripheral_int_enables <= rst_zero;
         analog_pin_select <= 3'h0;
         event_mask <= 3'h0;
      end else if (clk_en_i && wr_acc) begin
         case (reg_idx)
            idx_parallel_data_port: out_latch <= wbyte;
            idx_control_pin_port: ctrl_out <= wbyte[2:0];
            idx_interrupt_control: interrupt_control <= wbyte;
            idx_control_pin_direction_status: begin
               slave_mode_select <= wbyte[bit_mode];
               ctrl_dir <= wbyte[2:0];
            end
            idx_data_pin_direction: data_dir <= wbyte;
            idx_peripheral_int_enables: peripheral_int_enables <= wbyte;
            idx_analog_pin_config: analog_pin_select <= wbyte[2:0];
            idx_event_mask: event_mask <= wbyte[2:0];
            default: ;
         endcase
      end
   end

   // Port irq flag: set wins over firmware clear
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         peripheral_int_flags <= rst_zero;
      end else if (clk_en_i) begin
         if (wr_acc && reg_idx == idx_peripheral_int_flags) begin
            peripheral_int_flags <= wbyte;
         end
         if (completed) begin
            peripheral_int_flags[bit_port_irq] <= 1'b1;
         end
      end
   end

   // Event status, write one to clear, set wins
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         event_status <= 3'h0;
      end else if (clk_en_i) begin
         event_status <= (event_status
            & ~((wr_acc && reg_idx == idx_event_status) ? wbyte[2:0] : 3'h0))
            | {wr_start && input_full_flag, completed && !done_is_write,
               completed && done_is_write};
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         data_pin_o <= rst_zero;
         data_pin_oe_o <= rst_zero;
         ctrl_pin_o <= 3'h0;
         ctrl_pin_oe_o <= 3'h0;
         irq_o <= 1'b0;
         cpu_irq_o <= 1'b0;
      end else if (clk_en_i) begin
         data_pin_o <= out_latch;
         // Two cycles of sync delay plus the output register on drive; master must allow for it
         data_pin_oe_o <= slave_mode_select ? {8{rd_active}} : ~data_dir;
         ctrl_pin_o <= ctrl_out;
         ctrl_pin_oe_o <= slave_mode_select ? 3'h0 : ~ctrl_dir;
         irq_o <= |(event_status & event_mask);
         cpu_irq_o <= interrupt_control[bit_gie] && interrupt_control[bit_peie]
            && peripheral_int_flags[bit_port_irq]
            && peripheral_int_enables[bit_port_irq];
      end
   end

endmodule

/* File: tb/parallel_slave_port_properties.sv */
`timescale 1ns/1ps
module parallel_slave_port_properties (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [7:0] data_pin_o,
   input wire logic [7:0] data_pin_oe_o,
   input wire logic [2:0] ctrl_pin_i,
   input wire logic irq_o,
   input wire logic cpu_irq_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   logic act;
   logic prev_act;
   logic wr_acc;
   logic [7:0] since_end;
   assign act = !ctrl_pin_i[2] && !(ctrl_pin_i[0] && ctrl_pin_i[1]);
   assign wr_acc = psel_i && penable_i && pwrite_i && pready_o;
   // Starts saturated so an irq with no transfer behind it fails
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prev_act <= 1'b0;
         since_end <= 8'hff;
      end else begin
         prev_act <= act;
         if (prev_act && !act)
            since_end <= 8'h00;
         else if (since_end != 8'hff)
            since_end <= since_end + 8'h01;
      end
   end
   property p_ready_zero_wait;
      psel_i && $rose(penable_i) |-> pready_o;
   endproperty
   a_ready_zero_wait: assert property (p_ready_zero_wait)
      else $error("pready missing in access cycle");
   property p_ready_in_access;
      pready_o |-> psel_i && penable_i;
   endproperty
   a_ready_in_access: assert property (p_ready_in_access)
      else $error("pready outside access");
   property p_err_with_ready;
      pslverr_o |-> pready_o;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready)
      else $error("pslverr without pready");
   property p_err_read_zero;
      pslverr_o && !pwrite_i |-> prdata_o == 32'h00000000;
   endproperty
   a_err_read_zero: assert property (p_err_read_zero)
      else $error("refused read not zero");
   property p_oe_needs_read;
      $rose(data_pin_oe_o[0]) |-> !$past(ctrl_pin_i[0], 2) && !$past(ctrl_pin_i[2], 2);
   endproperty
   a_oe_needs_read: assert property (p_oe_needs_read)
      else $error("data pins driven without read");
   property p_oe_data_stable;
      data_pin_oe_o[0] && $past(data_pin_oe_o[0]) |-> $stable(data_pin_o);
   endproperty
   a_oe_data_stable: assert property (p_oe_data_stable)
      else $error("driven data moved");
   property p_irq_after_end;
      $rose(irq_o) |-> since_end >= 8'h03 && since_end <= 8'h0c;
   endproperty
   a_irq_after_end: assert property (p_irq_after_end)
      else $error("irq out of window");
   property p_irq_fall_by_write;
      $fell(irq_o) |-> $past(wr_acc) || $past(wr_acc, 2) || $past(wr_acc, 3);
   endproperty
   a_irq_fall_by_write: assert property (p_irq_fall_by_write)
      else $error("irq dropped alone");
   property p_cpu_irq_held;
      $fell(cpu_irq_o) |-> $past(wr_acc) || $past(wr_acc, 2) || $past(wr_acc, 3);
   endproperty
   a_cpu_irq_held: assert property (p_cpu_irq_held)
      else $error("cpu irq dropped alone");
endmodule
bind parallel_slave_port parallel_slave_port_properties i_parallel_slave_port_properties (
   .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .data_pin_o(data_pin_o), .data_pin_oe_o(data_pin_oe_o), .ctrl_pin_i(ctrl_pin_i),
   .irq_o(irq_o), .cpu_irq_o(cpu_irq_o));

/* File: tb/ext_cpu_model.sv */
`timescale 1ns/1ps
module ext_cpu_model (
   input wire logic clk_i,
   input wire logic [7:0] dev_data_i,
   input wire logic [7:0] dev_oe_i,
   output logic [7:0] data_o,
   output logic [2:0] ctrl_o
);
   import psp_pkg::*;
   strobe_type s = 3'h7;
   logic drv = 1'b0;
   logic [7:0] wdat = 8'h00;
   logic [7:0] last = 8'h00;
   // Undriven pins show the inverse of the last value, not a stale copy
   assign data_o = (dev_oe_i & dev_data_i) | (~dev_oe_i & (drv ? wdat : ~last));
   assign ctrl_o = {s.cs_b, s.wr_b, s.rd_b};
   task automatic write_byte(input logic [7:0] v, input int hold);
      @(posedge clk_i);
      s.cs_b <= 1'b0;
      s.wr_b <= 1'b0;
      drv <= 1'b1;
      wdat <= v;
      repeat (hold) @(posedge clk_i);
      s.cs_b <= 1'b1;
      s.wr_b <= 1'b1;
      @(posedge clk_i);
      drv <= 1'b0;
      last <= v;
      repeat (10) @(posedge clk_i);
   endtask
   task automatic read_byte(output logic [7:0] v, input int hold);
      @(posedge clk_i);
      s.cs_b <= 1'b0;
      s.rd_b <= 1'b0;
      repeat (hold) @(posedge clk_i);
      v = data_o;
      last <= data_o;
      s.cs_b <= 1'b1;
      s.rd_b <= 1'b1;
      repeat (10) @(posedge clk_i);
   endtask
endmodule

/* File: tb/parallel_slave_port_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module parallel_slave_port_tb;
   import psp_pkg::*;
   typedef struct packed {logic [7:0] idx; logic [7:0] val; logic err;} row_type;
   row_type rows [8] = '{'{8'h89, 8'h07, 1'b0}, '{8'h0c, 8'h00, 1'b0},
      '{8'h8c, 8'h00, 1'b0}, '{8'h9f, 8'h00, 1'b0}, '{8'h88, 8'hff, 1'b0},
      '{8'ha0, 8'h00, 1'b0}, '{8'ha1, 8'h00, 1'b0}, '{8'hff, 8'h00, 1'b1}};
   logic core_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, irq, cpu_irq;
   logic [7:0] d_in, d_out, d_oe, b;
   logic [2:0] ctrl, ctrl_o, ctrl_oe;
   logic clk_en = 1'b1;
   int fail_count = 0;
   int total_checks = 0;
   always #5 core_clk_i = ~core_clk_i;
   parallel_slave_port i_parallel_slave_port (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
      .clk_en_i(clk_en), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .data_pin_i(d_in), .data_pin_o(d_out), .data_pin_oe_o(d_oe),
      .ctrl_pin_i(ctrl), .ctrl_pin_o(ctrl_o), .ctrl_pin_oe_o(ctrl_oe), .irq_o(irq),
      .cpu_irq_o(cpu_irq));
   ext_cpu_model i_ext_cpu_model (.clk_i(core_clk_i), .dev_data_i(d_out),
      .dev_oe_i(d_oe), .data_o(d_in), .ctrl_o(ctrl));
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge core_clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h000000, wd};
      @(posedge core_clk_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         fail_count++;
         test_done();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, idx, d, r, e);
   endtask
   task automatic chk(input logic [7:0] idx, input logic [7:0] e, input logic ee = 1'b0);
      logic [31:0] r;
      logic x;
      apb(1'b0, idx, 8'h00, r, x);
      `CHK(r, {24'h000000, e})
      `CHK(x, ee)
   endtask
   task automatic clear_events;
      wr(idx_peripheral_int_flags, 8'h00);
      wr(idx_event_status, 8'h07);
   endtask
   initial begin
      int n;
      repeat (12) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      foreach (rows[i]) chk(rows[i].idx, rows[i].val, rows[i].err);
      $display("test reset_values done");
      wr(idx_peripheral_int_enables, 8'h80);
      wr(idx_interrupt_control, 8'hc0);
      wr(idx_event_mask, 8'h03);
      wr(idx_control_pin_direction_status, 8'h17);
      // Direction register cleared: slave mode must still keep pins released
      wr(idx_data_pin_direction, 8'h00);
      i_ext_cpu_model.write_byte(8'h5a, 4);
      n = 0;
      while (irq !== 1'b1 && n < 40) begin
         @(posedge core_clk_i);
         n++;
      end
      if (n >= 40) begin
         fail_count++;
         test_done();
      end
      `CHK(cpu_irq, 1'b1)
      `CHK(ctrl_oe, 3'h0)
      chk(idx_control_pin_direction_status, 8'h97);
      wr(idx_control_pin_direction_status, 8'h17);
      chk(idx_control_pin_direction_status, 8'h97);
      chk(idx_parallel_data_port, 8'h5a);
      chk(idx_control_pin_direction_status, 8'h17);
      chk(idx_peripheral_int_flags, 8'h80);
      clear_events();
      chk(idx_peripheral_int_flags, 8'h00);
      `CHK(irq, 1'b0)
      $display("test inbound done");
      i_ext_cpu_model.write_byte(8'ha5, 8);
      i_ext_cpu_model.write_byte(8'h3c, 4);
      chk(idx_control_pin_direction_status, 8'hb7);
      chk(idx_parallel_data_port, 8'h3c);
      chk(idx_control_pin_direction_status, 8'h37);
      wr(idx_data_pin_direction, 8'hff);
      wr(idx_control_pin_direction_status, 8'h27);
      chk(idx_control_pin_direction_status, 8'h27);
      wr(idx_control_pin_direction_status, 8'h17);
      chk(idx_control_pin_direction_status, 8'h17);
      clear_events();
      $display("test overflow done");
      wr(idx_parallel_data_port, 8'hc3);
      chk(idx_control_pin_direction_status, 8'h57);
      i_ext_cpu_model.read_byte(b, 6);
      `CHK(b, 8'hc3)
      chk(idx_control_pin_direction_status, 8'h17);
      chk(idx_peripheral_int_flags, 8'h80);
      `CHK(irq, 1'b1)
      clear_events();
      $display("test outbound done");
      wr(idx_parallel_data_port, 8'h11);
      wr(idx_control_pin_direction_status, 8'h07);
      chk(idx_control_pin_direction_status, 8'h07);
      i_ext_cpu_model.write_byte(8'h66, 4);
      chk(idx_peripheral_int_flags, 8'h00);
      `CHK(irq, 1'b0)
      $display("test mode_off done");
      rst_b_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      chk(idx_control_pin_direction_status, 8'h07);
      `CHK(irq, 1'b0)
      $display("test second_reset done");
      // Frozen clock enable: a whole strobe cycle must leave no trace
      wr(idx_control_pin_direction_status, 8'h17);
      clk_en <= 1'b0;
      i_ext_cpu_model.write_byte(8'h77, 4);
      clk_en <= 1'b1;
      repeat (12) @(posedge core_clk_i);
      chk(idx_control_pin_direction_status, 8'h17);
      chk(idx_peripheral_int_flags, 8'h00);
      $display("test freeze done");
      // Mode off: control pins follow their direction bits again, pins 0 and 1 as outputs
      wr(idx_control_pin_port, 8'h05);
      wr(idx_control_pin_direction_status, 8'h04);
      chk(idx_control_pin_direction_status, 8'h04);
      `CHK(ctrl_oe, 3'h3)
      `CHK(ctrl_o, 3'h5)
      $display("test gpio done");
      test_done();
   end
endmodule
